/* File: nps_cmd_engine.sv */
// command engine for the network parameter store, with its register port
`timescale 1ns/1ps
`include "nps_consts.svh"
module nps_cmd_engine #(
  parameter int unsigned CYC_PER_SEC = `NPS_SEC_NS / `NPS_CLK_NS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata,
  input wire logic link_pulse,
  input wire logic write_protect,
  input wire logic auto_start_setting,
  input wire logic socket_open,
  input wire logic client_msg,
  output logic socket_close,
  output nps_pkg::nps_par_t net_par,
  output logic net_par_valid,
  output logic [15:0] echo_port,
  output logic tp_port_active
);
  import nps_pkg::*;

  nps_st_t s;
  nps_st_t next_s;
  logic host_mem;
  logic eng_req;
  logic eng_we;
  logic [5:0] eng_addr;
  logic [15:0] eng_wdata;
  logic mem_we;
  logic [5:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic [15:0] limit;
  logic [31:0] eff_mask;
  logic [15:0] check_err;

  // bus address falls inside the command block memory
  function automatic logic is_mem(input logic [7:0] a);
    return a < 8'(`NPS_MEM_WORDS);
  endfunction

  // standard mask for the class of an address
  function automatic logic [31:0] class_mask(input logic [31:0] ip);
    if (!ip[31]) begin
      return 32'hFF00_0000;
    end else if (!ip[30]) begin
      return 32'hFFFF_0000;
    end
    return 32'hFFFF_FF00;
  endfunction

  // contiguous ones from the top, covering the class part, at least two host bits left
  function automatic logic mask_ok(input logic [31:0] ip, input logic [31:0] m);
    logic [31:0] inv;
    logic [31:0] host;
    inv = ~m;
    host = ip & inv;
    return ((inv & (inv + 32'h0000_0001)) == 32'h0000_0000) &&
      ((m & class_mask(ip)) == class_mask(ip)) &&
      (m[1:0] == 2'b00) &&
      (host != 32'h0000_0000) && (host != inv);
  endfunction

  // one word of the read answer, in write block order
  function automatic logic [15:0] answer_word(input nps_par_t p, input logic [3:0] i);
    unique case (i)
      4'h0: return `NPS_ETH_ID_HI;
      4'h1: return `NPS_ETH_ID_MID;
      4'h2: return `NPS_ETH_ID_LO;
      4'h3: return p.timeout;
      4'h4: return p.ip[31:16];
      4'h5: return p.ip[15:0];
      4'h6: return p.port;
      4'h7: return p.router[31:16];
      4'h8: return p.router[15:0];
      4'h9: return p.mask[31:16];
      4'hA: return p.mask[15:0];
      default: return 16'h0000;
    endcase
  endfunction

  nps_mem u_mem (
    .mclk(mclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // host bus always wins the memory so the master never waits; engine stalls
  always_comb begin
    host_mem = (bus_wr || bus_rd) && is_mem(bus_addr);
    eng_req = 1'b0;
    eng_we = 1'b0;
    eng_addr = 6'h00;
    eng_wdata = 16'h0000;
    unique case (s.state)
      NPS_FETCH: begin
        eng_req = s.idx <= `NPS_BLK_LAST;
        eng_addr = {2'b00, s.idx};
      end
      NPS_ANSWER: begin
        eng_req = 1'b1;
        eng_we = 1'b1;
        eng_addr = 6'(s.dest + {12'h000, s.idx});
        eng_wdata = answer_word(s.store, s.idx);
      end
      NPS_FINISH: begin
        eng_req = 1'b1;
        eng_we = 1'b1;
        eng_addr = `NPS_BLK_ERR;
        eng_wdata = s.err;
      end
      default: begin
        eng_req = 1'b0;
      end
    endcase
    mem_we = host_mem ? bus_wr : (eng_req && eng_we);
    mem_addr = host_mem ? bus_addr[5:0] : eng_addr;
    mem_wdata = host_mem ? bus_wdata : eng_wdata;
  end

  // checks on a fetched write block, first failure reported
  always_comb begin
    eff_mask = s.blk.mask;
    if (s.blk.mask == 32'h0000_0000) begin
      eff_mask = class_mask(s.blk.ip);
    end
    if (write_protect) begin
      check_err = `NPS_ERR_WPROT;
    end else if (s.blk.ip == 32'h0000_0000 || s.blk.ip > `NPS_IP_MAX) begin
      check_err = `NPS_ERR_IP;
    end else if (s.blk.router > `NPS_IP_MAX) begin
      check_err = `NPS_ERR_ROUTER;
    end else if (!mask_ok(s.blk.ip, eff_mask)) begin
      check_err = `NPS_ERR_MASK;
    end else begin
      check_err = `NPS_ERR_NONE;
    end
    limit = (s.count > `NPS_ANS_MAX) ? `NPS_ANS_MAX : s.count;
  end

  // next state of the whole block
  always_comb begin
    next_s = s;
    next_s.pend = 1'b0;
    next_s.close = 1'b0;
    next_s.rd_mem = bus_rd && is_mem(bus_addr);
    // control word: trigger and coupled-mode bits
    if (bus_wr && bus_addr == `NPS_OFS_CTRL) begin
      next_s.ctrl = bus_wdata[1:0];
    end
    if (bus_rd && !is_mem(bus_addr)) begin
      next_s.rd_reg = 16'h0000;
      if (bus_addr == `NPS_OFS_CTRL) begin
        next_s.rd_reg = {14'h0000, s.ctrl};
      end else if (bus_addr == `NPS_OFS_STATUS) begin
        next_s.rd_reg[`NPS_ST_BUSY] = !(s.state inside {NPS_IDLE, NPS_WAIT_ACK});
        next_s.rd_reg[`NPS_ST_DONE] = s.done;
        next_s.rd_reg[`NPS_ST_ERR] = s.err_flag;
        next_s.rd_reg[`NPS_ST_VALID] = s.store_valid;
        next_s.rd_reg[`NPS_ST_PORT] = s.aui;
      end
    end
    // port select follows the twisted-pair link detector
    next_s.aui = !link_pulse;
    // capture fetched block words one cycle after each read
    if (s.pend) begin
      unique case (s.pidx)
        4'h1: next_s.cmd = mem_rdata;
        4'h3: begin
          next_s.blk.timeout = mem_rdata;
          next_s.dest = mem_rdata;
        end
        4'h4: begin
          next_s.blk.ip[31:16] = mem_rdata;
          next_s.count = mem_rdata;
        end
        4'h5: next_s.blk.ip[15:0] = mem_rdata;
        4'h6: next_s.blk.port = mem_rdata;
        4'h7: next_s.blk.router[31:16] = mem_rdata;
        4'h8: next_s.blk.router[15:0] = mem_rdata;
        4'h9: next_s.blk.mask[31:16] = mem_rdata;
        4'hA: next_s.blk.mask[15:0] = mem_rdata;
        default: next_s.cmd = s.cmd;
      endcase
    end
    unique case (s.state)
      NPS_IDLE: begin
        if (s.ctrl[`NPS_CTRL_TRIG]) begin
          next_s.state = NPS_FETCH;
          next_s.idx = `NPS_BLK_FIRST;
          next_s.done = 1'b0;
        end
      end
      NPS_FETCH: begin
        if (eng_req && !host_mem) begin
          next_s.pend = 1'b1;
          next_s.pidx = s.idx;
          next_s.idx = s.idx + 4'h1;
        end
        if (s.pend && s.pidx == `NPS_BLK_LAST) begin
          next_s.state = NPS_CHECK;
        end
      end
      NPS_CHECK: begin
        next_s.state = NPS_FINISH;
        next_s.idx = 4'h0;
        if (s.cmd == `NPS_CMD_WRITE) begin
          next_s.err = check_err;
          if (check_err == `NPS_ERR_NONE) begin
            next_s.store = s.blk;
            next_s.store.mask = eff_mask;
            next_s.store_valid = 1'b1;
          end
        end else if (s.cmd == `NPS_CMD_READ) begin
          if (s.count < `NPS_ANS_MIN) begin
            next_s.err = `NPS_ERR_COUNT;
          end else begin
            next_s.err = `NPS_ERR_NONE;
            next_s.state = NPS_ANSWER;
          end
        end else begin
          next_s.err = `NPS_ERR_CMD;
        end
      end
      NPS_ANSWER: begin
        if (!host_mem) begin
          next_s.idx = s.idx + 4'h1;
          if ({12'h000, s.idx} == limit - 16'h0001) begin
            next_s.state = NPS_FINISH;
          end
        end
      end
      NPS_FINISH: begin
        if (!host_mem) begin
          next_s.done = 1'b1;
          next_s.err_flag = s.err != `NPS_ERR_NONE;
          // uncoupled mode repeats for as long as the trigger stays set
          next_s.state = s.ctrl[`NPS_CTRL_COUPLED] ? NPS_WAIT_ACK : NPS_IDLE;
        end
      end
      NPS_WAIT_ACK: begin
        if (!s.ctrl[`NPS_CTRL_TRIG]) begin
          next_s.state = NPS_IDLE;
        end
      end
    endcase
    // parameters in use come from the store only once it holds valid data
    next_s.act_valid = auto_start_setting && s.store_valid;
    next_s.act = next_s.act_valid ? s.store : '0;
    // stale socket timer, restarted by any client message
    if (!socket_open || client_msg || s.act.timeout == 16'h0000) begin
      next_s.cyc = 32'h0000_0000;
      next_s.secs = 16'h0000;
    end else if (s.cyc == 32'(CYC_PER_SEC - 1)) begin
      next_s.cyc = 32'h0000_0000;
      next_s.secs = s.secs + 16'h0001;
      if (s.secs + 16'h0001 >= s.act.timeout) begin
        next_s.close = 1'b1;
        next_s.secs = 16'h0000;
      end
    end else begin
      next_s.cyc = s.cyc + 32'h0000_0001;
    end
  end

  // one register bank for all control state
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.state <= NPS_IDLE;
      s.aui <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // read data from the memory register or the register-read flop
  assign bus_rdata = s.rd_mem ? mem_rdata : s.rd_reg;
  assign socket_close = s.close;
  assign net_par = s.act;
  assign net_par_valid = s.act_valid;
  assign echo_port = `NPS_ECHO_PORT;
  assign tp_port_active = !s.aui;
endmodule

/* File: nps_consts.svh */
// constants for the network parameter store command engine
`ifndef NPS_CONSTS_SVH
`define NPS_CONSTS_SVH
`define NPS_CLK_NS 25
`define NPS_SEC_NS 1000000000
`define NPS_MEM_WORDS 64
`define NPS_OFS_CTRL 8'h0040
`define NPS_OFS_STATUS 8'h0041
`define NPS_BLK_ERR 6'h00
`define NPS_BLK_FIRST 4'h1
`define NPS_BLK_LAST 4'hA
`define NPS_CMD_WRITE 16'h000C
`define NPS_CMD_READ 16'h000D
`define NPS_ANS_MAX 16'h000B
`define NPS_ANS_MIN 16'h0009
`define NPS_IP_MAX 32'hDFFF_FFFF
`define NPS_ECHO_PORT 16'h0007
`define NPS_CTRL_TRIG 0
`define NPS_CTRL_COUPLED 1
`define NPS_ST_BUSY 0
`define NPS_ST_DONE 1
`define NPS_ST_ERR 2
`define NPS_ST_VALID 3
`define NPS_ST_PORT 6
`define NPS_ERR_NONE 16'h0000
`define NPS_ERR_WPROT 16'h0001
`define NPS_ERR_IP 16'h0002
`define NPS_ERR_ROUTER 16'h0003
`define NPS_ERR_MASK 16'h0004
`define NPS_ERR_CMD 16'h0005
`define NPS_ERR_COUNT 16'h0006
`define NPS_ETH_ID_HI 16'h0000
`define NPS_ETH_ID_MID 16'h0000
`define NPS_ETH_ID_LO 16'h0001
`endif

/* File: nps_pkg.sv */
// types for the network parameter store command engine
package nps_pkg;
  typedef enum logic [5:0] {
    NPS_IDLE = 6'b00_0001,
    NPS_FETCH = 6'b00_0010,
    NPS_CHECK = 6'b00_0100,
    NPS_ANSWER = 6'b00_1000,
    NPS_FINISH = 6'b01_0000,
    NPS_WAIT_ACK = 6'b10_0000
  } nps_state_t;

  typedef struct packed {
    logic [15:0] timeout;
    logic [31:0] ip;
    logic [15:0] port;
    logic [31:0] router;
    logic [31:0] mask;
  } nps_par_t;

  typedef struct packed {
    nps_state_t state;
    logic [3:0] idx;
    logic pend;
    logic [3:0] pidx;
    logic [15:0] cmd;
    logic [15:0] dest;
    logic [15:0] count;
    nps_par_t blk;
    nps_par_t store;
    logic store_valid;
    nps_par_t act;
    logic act_valid;
    logic [15:0] err;
    logic [1:0] ctrl;
    logic done;
    logic err_flag;
    logic aui;
    logic rd_mem;
    logic [15:0] rd_reg;
    logic [31:0] cyc;
    logic [15:0] secs;
    logic close;
  } nps_st_t;
endpackage

/* File: nps_mem.sv */
// command block memory, one port, registered read data
`timescale 1ns/1ps
`include "nps_consts.svh"
module nps_mem (
  input wire logic mclk,
  input wire logic we,
  input wire logic [5:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:`NPS_MEM_WORDS-1];

  // no reset on the array: software sets up every block before triggering
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

/* File: nps_cmd_monitor.sv */
// assertion checker for the network parameter store command engine
`timescale 1ns/1ps
module nps_cmd_monitor
  import nps_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic link_pulse,
  input wire logic write_protect,
  input wire logic auto_start_setting,
  input wire logic socket_open,
  input wire logic client_msg,
  input wire logic socket_close,
  input wire nps_pkg::nps_par_t net_par,
  input wire logic net_par_valid,
  input wire logic [15:0] echo_port,
  input wire logic tp_port_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  echo_port_a: assert property (echo_port == 16'h0007)
    else $error("echo port is not 7");
  // port choice follows the link one edge late; skipped right after reset
  port_select_a: assert property (!$past(rst) |-> tp_port_active == $past(link_pulse))
    else $error("port select does not follow link pulses");
  status_port_a: assert property (bus_rd && bus_addr == 8'h41 |=>
    bus_rdata[6] == !$past(tp_port_active))
    else $error("status bit 6 disagrees with active port");
  unmapped_read_a: assert property (bus_rd && bus_addr > 8'h41 |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  close_cause_a: assert property (socket_close |-> $past(socket_open) && !$past(client_msg))
    else $error("socket closed without idle open socket");
  close_pulse_a: assert property (socket_close |=> !socket_close)
    else $error("close pulse longer than one cycle");
  auto_gate_a: assert property (!$past(auto_start_setting) |-> !net_par_valid)
    else $error("parameters valid without auto start");
  par_zero_a: assert property (!net_par_valid |-> net_par == '0)
    else $error("parameters shown while not valid");
  ip_range_a: assert property (net_par_valid |->
    net_par.ip != 32'h0000_0000 && net_par.ip <= 32'hDFFF_FFFF)
    else $error("stored ip out of range");
  router_range_a: assert property (net_par_valid |-> net_par.router <= 32'hDFFF_FFFF)
    else $error("stored router out of range");
  mask_shape_a: assert property (net_par_valid |->
    net_par.mask[1:0] == 2'b00 && net_par.mask[31:24] == 8'hFF)
    else $error("stored mask malformed");
endmodule
bind nps_cmd_engine nps_cmd_monitor i_mon (.mclk, .rst, .bus_addr, .bus_wdata, .bus_wr,
  .bus_rd, .bus_rdata, .link_pulse, .write_protect, .auto_start_setting, .socket_open,
  .client_msg, .socket_close, .net_par, .net_par_valid, .echo_port, .tp_port_active);

/* File: nps_plc_model.sv */
// host controller model: register port master and command block layout
`timescale 1ns/1ps
module nps_plc_model (
  input wire logic mclk,
  output logic [7:0] bus_addr,
  output logic [15:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic [15:0] bus_rdata
);
  initial begin
    bus_addr = 8'h00;
    bus_wdata = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask
  // memory read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    @(posedge mclk);
    d = bus_rdata;
  endtask
  // whole block: error word zeroed, connection number, reserved words zero
  task automatic blk(input logic [15:0] c, input logic [127:0] f);
    logic [15:0] w;
    for (int i = 0; i < 16; i++) begin
      w = (i >= 3 && i <= 10) ? f[127 - 16 * (i - 3) -: 16] : 16'h0000;
      if (i == 1) w = c;
      if (i == 2) w = 16'h4B00;
      wr(i[7:0], w);
    end
  endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the network parameter store command engine
`timescale 1ns/1ps
`include "nps_consts.svh"
module testbench;
  import nps_pkg::*;
  logic mclk, rst, link_pulse, write_protect, auto_start_setting, socket_open, client_msg;
  logic [7:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata, echo_port, d, e, ans[11];
  logic bus_wr, bus_rd, socket_close, net_par_valid, tp_port_active, sv, lp_q, lp_ok;
  nps_par_t net_par;
  logic [31:0] s_ip, s_r, s_m, me;
  logic [15:0] s_t, s_p;
  logic [96:0] tbl[10];
  integer errors, n_tests, seed, cyc, n;
  nps_plc_model host (.mclk(mclk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  nps_cmd_engine #(.CYC_PER_SEC(10)) i_nps_cmd_engine (.mclk(mclk), .rst(rst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .link_pulse(link_pulse), .write_protect(write_protect),
    .auto_start_setting(auto_start_setting), .socket_open(socket_open),
    .client_msg(client_msg), .socket_close(socket_close), .net_par(net_par),
    .net_par_valid(net_par_valid), .echo_port(echo_port), .tp_port_active(tp_port_active));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, well above the few thousand cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      report_and_stop;
    end
  end
  // link pulses wander at random; port flag must follow them one edge late
  always @(posedge mclk) begin
    if (!rst && lp_ok) chk(tp_port_active, lp_q);
    lp_ok <= !rst;
    lp_q <= link_pulse;
    link_pulse <= $random(seed);
  end
  // expected error code and effective mask, class mask when zero is given
  function automatic logic [15:0] ferr(input logic [96:0] t, output logic [31:0] m);
    logic [31:0] c, h, ip;
    ip = t[95:64];
    c = ip[31:30] == 2'b11 ? 32'hFFFF_FF00 : ip[31] ? 32'hFFFF_0000 : 32'hFF00_0000;
    m = t[31:0] == 32'h0 ? c : t[31:0];
    h = ip & ~m;
    if (t[96]) return 16'h0001;
    if (ip == 0 || ip > 32'hDFFF_FFFF) return 16'h0002;
    if (t[63:32] > 32'hDFFF_FFFF) return 16'h0003;
    if ((~m & (~m + 1)) != 0 || (m & c) != c || m[1:0] != 0 || h == 0 || h == ~m)
      return 16'h0004;
    return 16'h0000;
  endfunction
  // coupled trigger, wait for done, prove no rerun, then acknowledge
  task automatic run(output logic [15:0] er);
    host.wr(8'h40, 16'h0003);
    repeat (3) @(posedge mclk);
    d = 16'h0000;
    for (int k = 0; k < 300 && d[1] !== 1'b1; k++) host.rd(8'h41, d);
    host.rd(8'h00, er);
    host.rd(8'h41, d);
    chk(d[2], er != 0);
    host.wr(8'h00, 16'hFFFF);
    repeat (40) @(posedge mclk);
    host.rd(8'h00, d);
    chk(d, 16'hFFFF);
    host.wr(8'h40, 16'h0000);
  endtask
  task automatic wcmd(input logic [96:0] t, input logic [15:0] tmo);
    logic [15:0] x;
    write_protect <= t[96];
    x = ferr(t, me);
    host.blk(`NPS_CMD_WRITE, {tmo, t[95:64], 16'h05E1, t[63:32], t[31:0]});
    run(e);
    chk(e, x);
    if (x == 0) {sv, s_t, s_ip, s_p, s_r, s_m} = {1'b1, tmo, t[95:64], 16'h05E1, t[63:32], me};
    repeat (2) @(posedge mclk);
    chk(net_par_valid, sv);
    if (sv) chk(net_par, {s_t, s_ip, s_p, s_r, s_m});
    $display("write test done, code %h", x);
  endtask
  task automatic sock(input integer lim);
    socket_open <= 1'b1;
    for (n = 0; n < lim && socket_close !== 1'b1; n++) @(posedge mclk);
    socket_open <= 1'b0;
  endtask
  initial begin
    errors = 0;
    n_tests = 0;
    cyc = 0;
    seed = 32'h9b2e;
    sv = 1'b0;
    {rst, link_pulse, write_protect, socket_open, client_msg} = 5'b1_0000;
    {lp_q, lp_ok} = 2'b00;
    auto_start_setting = 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    chk(net_par_valid, 1'b0);
    chk(echo_port, 16'h0007);
    tbl = '{{1'b0, 32'h0A01_0203, 32'h0, 32'h0}, {1'b1, 32'h0A01_0204, 32'h0, 32'h0},
      {1'b0, 32'h0, 32'h0, 32'h0}, {1'b0, 32'hE000_0001, 32'h0, 32'h0},
      {1'b0, 32'hDFFF_FF01, 32'hDFFF_FFFF, 32'h0}, {1'b0, 32'h0A01_0203, 32'hE000_0000, 32'h0},
      {1'b0, 32'h0A01_0203, 32'h0, 32'hFFFF_FFFE}, {1'b0, 32'h0A01_0203, 32'h0, 32'hFF00_FF00},
      {1'b0, 32'h0A01_0200, 32'h0, 32'hFFFF_FF00}, {1'b0, 32'h8102_0000, 32'hC0A8_0001, 32'h0}};
    tbl[0][87:64] = $random(seed);
    tbl[9][79:64] = $random(seed);
    tbl[9][31:0] = 32'hFFFF_FFC0;
    foreach (tbl[i]) wcmd(tbl[i], 16'h0003);
    ans = '{`NPS_ETH_ID_HI, `NPS_ETH_ID_MID, `NPS_ETH_ID_LO, s_t, s_ip[31:16], s_ip[15:0], s_p,
      s_r[31:16], s_r[15:0], s_m[31:16], s_m[15:0]};
    for (int j = 0; j < 4; j++) begin
      for (int i = 0; i < 12; i++) host.wr(8'h20 + i[7:0], 16'hA5A5);
      host.blk(`NPS_CMD_READ, {16'h0020, 16'(8 + j + j / 2 + j / 3 * 0), 96'h0});
      run(e);
      n = 8 + j + j / 2;
      chk(e, n < 9 ? 16'h0006 : 16'h0000);
      for (int i = 0; i < 12; i++) begin
        host.rd(8'h20 + i[7:0], d);
        chk(d, (n >= 9 && i < (n > 11 ? 11 : n)) ? ans[i] : 16'hA5A5);
      end
      $display("read test done, count %0d", n);
    end
    host.blk(16'h0007, 128'h0);
    run(e);
    chk(e, 16'h0005);
    host.wr(8'h90, 16'h1234);
    host.rd(8'h90, d);
    chk(d, 16'h0000);
    sock(100);
    chk(n >= 28 && n <= 33, 1'b1);
    wcmd({1'b0, s_ip, s_r, s_m}, 16'h0000);
    sock(100);
    chk(n, 100);
    $display("socket and misc tests done");
    report_and_stop;
  end
endmodule
